// ### hw/i2css_pkg.sv
// i2css_pkg: shared constants and types for the i2c slave status block
// assumes a 16-bit register port and one synchronous reset domain
package i2css_pkg;
    // register offsets
    localparam logic [15:0] OFS_BUS_STATUS    = 16'h4368;
    localparam logic [15:0] OFS_ACCESS_STATUS = 16'h436a;
    localparam logic [15:0] OFS_IRQ_ENABLE    = 16'h436c;
    localparam logic [15:0] OFS_CONTROL       = 16'h4360;
    localparam logic [15:0] OFS_TRANSMIT      = 16'h4362;
    localparam logic [15:0] OFS_RECEIVE       = 16'h4364;
    // bus status bit positions
    localparam int BIT_AGGREGATE = 7;
    localparam int BIT_UDF_OVF   = 5;
    localparam int BIT_BUS_FREE  = 4;
    localparam int BIT_MISMATCH  = 3;
    localparam int BIT_ASYNC     = 2;
    localparam int BIT_NAK       = 1;
    localparam int BIT_STOP      = 0;
    // access status bit positions
    localparam int BIT_RX_READY  = 4;
    localparam int BIT_TX_EMPTY  = 3;
    localparam int BIT_BUSY      = 2;
    localparam int BIT_SELECTED  = 1;
    localparam int BIT_DIRECTION = 0;
    // interrupt enable bit positions
    localparam int BIT_BUS_IEN   = 2;
    localparam int BIT_RX_IEN    = 1;
    localparam int BIT_TX_IEN    = 0;
    // control register layout, reset values and bits per byte
    localparam int BIT_ASYNC_EN  = 8;
    localparam logic [6:0]  RST_OWN_ADDR = 7'h00;
    localparam logic [15:0] RST_REG      = 16'h0000;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    // sticky bus status flags
    typedef struct packed {
        logic udf_ovf;
        logic bus_free;
        logic mismatch;
        logic async_det;
        logic nak;
        logic stop;
    } i2css_flags_s;
    // engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_ADDR_NAK,
        ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
    } i2css_state_e;
endpackage

// ### hw/i2css_top.sv
// i2css_top: i2c slave engine with status flags and interrupt requests
// assumes open-drain bus lines resolved outside, pins asynchronous to clock
// Behaviour
// - flag mismatch between driven and sampled data
// - sticky flags cleared only by writing one
// - no mismatch from own nak in async mode
// - async mode flags own address detection
// - async address detection answers with nak
// - nak flag records master nak after a sent byte
// - stop or restart while selected sets flag
// - bus irq is aggregate flag and enable
// - receive ready set on load, read clears
// - transmit empty set when sent, write clears
// - receive irq on receive load if enabled
// - transmit irq on shift load if enabled
// - busy on start or low line, stop clears
// - selected on own address outside async mode, stop clears
// - direction bit latched from address byte
// - enable register bits two to zero, reset zero
// - aggregate flag is or of sticky flags
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module i2css_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // bus lines
    input  wire logic        bus_clock_line_in,
    input  wire logic        bus_data_line_in,
    output logic             bus_data_line_out,
    output logic             bus_data_line_oe,
    // bus free request event, already qualified
    input  wire logic        bus_free_req,
    // interrupt requests to the interrupt controller
    output logic             irq_bus_status,
    output logic             irq_receive,
    output logic             irq_transmit
);
    // pin synchronisers, third stage only for edge finding
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], bus_clock_line_in};
            sda_sync_r <= {sda_sync_r[1:0], bus_data_line_in};
        end
    end

    // line events taken from stages two and three
    wire scl_now   = scl_sync_r[1];
    wire sda_now   = sda_sync_r[1];
    wire scl_rise  = scl_now & ~scl_sync_r[2];
    wire scl_fall  = ~scl_now & scl_sync_r[2];
    wire start_cnd = scl_now & scl_sync_r[2] & ~sda_now & sda_sync_r[2];
    wire stop_cnd  = scl_now & scl_sync_r[2] & sda_now & ~sda_sync_r[2];

    // register decode
    wire hit_bus  = reg_addr == i2css_pkg::OFS_BUS_STATUS;
    wire hit_acc  = reg_addr == i2css_pkg::OFS_ACCESS_STATUS;
    wire hit_ien  = reg_addr == i2css_pkg::OFS_IRQ_ENABLE;
    wire hit_ctl  = reg_addr == i2css_pkg::OFS_CONTROL;
    wire hit_trn  = reg_addr == i2css_pkg::OFS_TRANSMIT;
    wire hit_rcv  = reg_addr == i2css_pkg::OFS_RECEIVE;
    wire wr_bus   = reg_wr & hit_bus;
    wire wr_trn   = reg_wr & hit_trn;
    wire rd_rcv   = reg_rd & hit_rcv;

    // software registers
    logic [2:0]  ien_r;
    logic [6:0]  own_addr_r;
    logic        async_en_r;
    logic [7:0]  trn_data_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ien_r      <= 3'h0;
            own_addr_r <= i2css_pkg::RST_OWN_ADDR;
            async_en_r <= 1'b0;
            trn_data_r <= 8'h00;
        end else begin
            if (reg_wr & hit_ien)
                ien_r <= reg_wdata[2:0];
            if (reg_wr & hit_ctl) begin
                own_addr_r <= reg_wdata[6:0];
                async_en_r <= reg_wdata[i2css_pkg::BIT_ASYNC_EN];
            end
            if (wr_trn)
                trn_data_r <= reg_wdata[7:0];
        end
    end

    // engine state
    i2css_pkg::i2css_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] rcv_data_r, rcv_data_nxt;
    logic       out_bit_r, out_bit_nxt;
    logic       drive_r, drive_nxt;
    logic       sel_r, sel_nxt;
    logic       dir_r, dir_nxt;
    logic       busy_r, busy_nxt;
    logic       rx_ready_r, tx_empty_r;
    i2css_pkg::i2css_flags_s flags_r;

    // events produced by the engine
    logic set_mis, set_async, set_nak, set_stop, set_uo;
    logic ev_rx_load, ev_tx_load, ev_tx_sent;

    // address match on the seven shifted bits
    wire addr_match = sh_r[7:1] == own_addr_r;
    wire last_bit   = cnt_r == i2css_pkg::BITS_PER_BYTE;

    // next state and events; start and stop override the byte phases
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        sh_nxt       = sh_r;
        rcv_data_nxt = rcv_data_r;
        out_bit_nxt  = out_bit_r;
        drive_nxt    = drive_r;
        sel_nxt      = sel_r;
        dir_nxt      = dir_r;
        busy_nxt     = busy_r;
        set_mis      = 1'b0;
        set_async    = 1'b0;
        set_nak      = 1'b0;
        set_stop     = 1'b0;
        set_uo       = 1'b0;
        ev_rx_load   = 1'b0;
        ev_tx_load   = 1'b0;
        ev_tx_sent   = 1'b0;
        // line low or start marks the bus busy
        if (start_cnd | ~scl_now | ~sda_now)
            busy_nxt = 1'b1;
        // mismatch check while this end drives a bit
        if (scl_rise & drive_r & (sda_now != out_bit_r))
            set_mis = 1'b1;
        case (state_r)
            i2css_pkg::ST_ADDR: begin
                if (scl_rise) begin
                    sh_nxt  = {sh_r[6:0], sda_now};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall & last_bit) begin
                    cnt_nxt = 4'h0;
                    if (addr_match & async_en_r) begin
                        set_async   = 1'b1;
                        state_nxt   = i2css_pkg::ST_ADDR_NAK;
                        drive_nxt   = 1'b0;
                        out_bit_nxt = 1'b1;
                    end else if (addr_match) begin
                        sel_nxt     = 1'b1;
                        dir_nxt     = sh_r[0];
                        state_nxt   = i2css_pkg::ST_ADDR_ACK;
                        drive_nxt   = 1'b1;
                        out_bit_nxt = 1'b0;
                    end else begin
                        // released line stands for our nak
                        state_nxt   = i2css_pkg::ST_ADDR_NAK;
                        drive_nxt   = 1'b1;
                        out_bit_nxt = 1'b1;
                    end
                end
            end
            i2css_pkg::ST_ADDR_NAK: begin
                // other slave acking is no fault in async mode
                if (scl_rise & ~sda_now & async_en_r)
                    set_mis = 1'b0;
                if (scl_fall) begin
                    drive_nxt   = 1'b0;
                    out_bit_nxt = 1'b1;
                    state_nxt   = i2css_pkg::ST_IDLE;
                end
            end
            i2css_pkg::ST_ADDR_ACK, i2css_pkg::ST_TX_ACK: begin
                if (scl_rise & (state_r == i2css_pkg::ST_TX_ACK))
                    set_nak = sda_now;
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    if (state_r == i2css_pkg::ST_TX_ACK & sda_now) begin
                        drive_nxt   = 1'b0;
                        out_bit_nxt = 1'b1;
                        state_nxt   = i2css_pkg::ST_IDLE;
                    end else if (dir_r) begin
                        ev_tx_load  = 1'b1;
                        set_uo      = tx_empty_r;
                        sh_nxt      = {trn_data_r[6:0], 1'b0};
                        out_bit_nxt = trn_data_r[7];
                        drive_nxt   = 1'b1;
                        cnt_nxt     = 4'h1;
                        state_nxt   = i2css_pkg::ST_TX;
                    end else begin
                        drive_nxt   = 1'b0;
                        out_bit_nxt = 1'b1;
                        state_nxt   = i2css_pkg::ST_RX;
                    end
                end
            end
            i2css_pkg::ST_RX: begin
                if (scl_rise) begin
                    sh_nxt  = {sh_r[6:0], sda_now};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall & last_bit) begin
                    rcv_data_nxt = sh_r;
                    ev_rx_load   = 1'b1;
                    set_uo       = rx_ready_r;
                    drive_nxt    = 1'b1;
                    out_bit_nxt  = 1'b0;
                    cnt_nxt      = 4'h0;
                    state_nxt    = i2css_pkg::ST_RX_ACK;
                end
            end
            i2css_pkg::ST_RX_ACK: begin
                if (scl_fall) begin
                    drive_nxt   = 1'b0;
                    out_bit_nxt = 1'b1;
                    state_nxt   = i2css_pkg::ST_RX;
                end
            end
            i2css_pkg::ST_TX: begin
                if (scl_fall & last_bit) begin
                    ev_tx_sent  = 1'b1;
                    drive_nxt   = 1'b0;
                    out_bit_nxt = 1'b1;
                    state_nxt   = i2css_pkg::ST_TX_ACK;
                end else if (scl_fall) begin
                    out_bit_nxt = sh_r[7];
                    sh_nxt      = {sh_r[6:0], 1'b0};
                    cnt_nxt     = cnt_r + 4'h1;
                end
            end
            default: ;
        endcase
        // restart or stop resets the transfer process
        if (start_cnd | stop_cnd) begin
            set_stop    = sel_r;
            sel_nxt     = 1'b0;
            drive_nxt   = 1'b0;
            out_bit_nxt = 1'b1;
            cnt_nxt     = 4'h0;
            state_nxt   = start_cnd ? i2css_pkg::ST_ADDR : i2css_pkg::ST_IDLE;
        end
        if (stop_cnd)
            busy_nxt = 1'b0;
    end

    // engine registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r    <= i2css_pkg::ST_IDLE;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            rcv_data_r <= 8'h00;
            out_bit_r  <= 1'b1;
            drive_r    <= 1'b0;
            sel_r      <= 1'b0;
            dir_r      <= 1'b0;
            busy_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            rcv_data_r <= rcv_data_nxt;
            out_bit_r  <= out_bit_nxt;
            drive_r    <= drive_nxt;
            sel_r      <= sel_nxt;
            dir_r      <= dir_nxt;
            busy_r     <= busy_nxt;
        end
    end

    // write-one clear mask for sticky flags, zero bits keep the flag
    function automatic logic keep(input logic f, input int b);
        keep = f & ~(wr_bus & reg_wdata[b]);
    endfunction

    // sticky flags: a set in the clearing cycle wins
    i2css_pkg::i2css_flags_s flags_nxt;
    always_comb begin
        flags_nxt.udf_ovf   = set_uo | keep(flags_r.udf_ovf, i2css_pkg::BIT_UDF_OVF);
        flags_nxt.bus_free  = bus_free_req
                            | keep(flags_r.bus_free, i2css_pkg::BIT_BUS_FREE);
        flags_nxt.mismatch  = set_mis | keep(flags_r.mismatch, i2css_pkg::BIT_MISMATCH);
        flags_nxt.async_det = set_async | keep(flags_r.async_det, i2css_pkg::BIT_ASYNC);
        flags_nxt.nak       = set_nak | keep(flags_r.nak, i2css_pkg::BIT_NAK);
        flags_nxt.stop      = set_stop | keep(flags_r.stop, i2css_pkg::BIT_STOP);
    end

    // data flags: hardware set beats software clear
    wire rx_ready_nxt = ev_rx_load | (rx_ready_r & ~rd_rcv);
    wire tx_empty_nxt = ev_tx_sent | (tx_empty_r & ~wr_trn);
    wire aggregate    = |flags_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flags_r    <= '0;
            rx_ready_r <= 1'b0;
            tx_empty_r <= 1'b0;
        end else begin
            flags_r    <= flags_nxt;
            rx_ready_r <= rx_ready_nxt;
            tx_empty_r <= tx_empty_nxt;
        end
    end

    // read mux, reserved bits and unmapped offsets read zero
    wire [15:0] bus_word = {8'h00, aggregate, 1'b0, flags_r.udf_ovf,
                            flags_r.bus_free, flags_r.mismatch,
                            flags_r.async_det, flags_r.nak, flags_r.stop};
    wire [15:0] acc_word = {11'h000, rx_ready_r, tx_empty_r, busy_r, sel_r, dir_r};
    wire [15:0] ctl_word = {7'h00, async_en_r, 1'b0, own_addr_r};
    logic [15:0] rd_sel;
    always_comb begin
        if (hit_bus)
            rd_sel = bus_word;
        else if (hit_acc)
            rd_sel = acc_word;
        else if (hit_ien)
            rd_sel = {13'h0000, ien_r};
        else if (hit_ctl)
            rd_sel = ctl_word;
        else if (hit_trn)
            rd_sel = {8'h00, trn_data_r};
        else if (hit_rcv)
            rd_sel = {8'h00, rcv_data_r};
        else
            rd_sel = 16'h0000;
    end

    // registered outputs; data is driven low only, never high
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata         <= 16'h0000;
            bus_data_line_out <= 1'b0;
            bus_data_line_oe  <= 1'b0;
            irq_bus_status    <= 1'b0;
            irq_receive       <= 1'b0;
            irq_transmit      <= 1'b0;
        end else begin
            reg_rdata         <= reg_rd ? rd_sel : 16'h0000;
            bus_data_line_out <= 1'b0;
            bus_data_line_oe  <= drive_nxt & ~out_bit_nxt;
            irq_bus_status    <= (|flags_nxt) & ien_r[i2css_pkg::BIT_BUS_IEN];
            irq_receive       <= ev_rx_load & ien_r[i2css_pkg::BIT_RX_IEN];
            irq_transmit      <= ev_tx_load & ien_r[i2css_pkg::BIT_TX_IEN];
        end
    end
endmodule

// ### dv/i2css_properties.sv
// i2css_props: port-level checks of the slave status block
// assumes a bind onto i2css_top, one clock domain, synchronous reset
`timescale 1ns/100ps
module i2css_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // bus lines and requests
    input wire logic        bus_clock_line_in,
    input wire logic        bus_data_line_in,
    input wire logic        bus_data_line_out,
    input wire logic        bus_data_line_oe,
    input wire logic        bus_free_req,
    input wire logic        irq_bus_status,
    input wire logic        irq_receive,
    input wire logic        irq_transmit
);
    logic [2:0] ien_r;
    logic       rd_bus;
    logic       rd_acc;
    logic       rd_ien;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // reads under watch
    assign rd_bus = reg_rd && reg_addr == i2css_pkg::OFS_BUS_STATUS;
    assign rd_acc = reg_rd && reg_addr == i2css_pkg::OFS_ACCESS_STATUS;
    assign rd_ien = reg_rd && reg_addr == i2css_pkg::OFS_IRQ_ENABLE;
    // shadow of the enables, so gating is judged without looking inside
    always_ff @(posedge clock) begin
        if (sys_rst)
            ien_r <= 3'h0;
        else if (reg_wr && reg_addr == i2css_pkg::OFS_IRQ_ENABLE)
            ien_r <= reg_wdata[2:0];
    end
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    agg_or_a: assert property (rd_bus |=> reg_rdata[7] == |reg_rdata[5:0])
        else $error("aggregate flag differs from or of sticky flags");
    stat_rsvd_a: assert property (rd_bus |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[6])
        else $error("bus status reserved bits not zero");
    acc_rsvd_a: assert property (rd_acc |=> reg_rdata[15:5] == 11'h000)
        else $error("access status reserved bits not zero");
    ien_read_a: assert property (rd_ien |=> reg_rdata == {13'h0000, ien_r})
        else $error("enable register reads wrong value");
    rx_pulse_a: assert property (irq_receive |=> !irq_receive)
        else $error("receive request longer than one cycle");
    tx_pulse_a: assert property (irq_transmit |=> !irq_transmit)
        else $error("transmit request longer than one cycle");
    rx_gate_a: assert property (irq_receive |-> ien_r[1] || $past(ien_r[1]))
        else $error("receive request while disabled");
    tx_gate_a: assert property (irq_transmit |-> ien_r[0] || $past(ien_r[0]))
        else $error("transmit request while disabled");
    bus_gate_a: assert property (irq_bus_status |-> ien_r[2] || $past(ien_r[2]))
        else $error("bus status request while disabled");
    // main scenarios reached
    cover property (irq_receive);
    cover property (irq_transmit);
    cover property ($rose(irq_bus_status));
endmodule

// ### dv/i2css_master.sv
// i2css_master: behavioural i2c bus master facing the slave block
// assumes the bench resolves open-drain lines with pull-ups to high
`timescale 1ns/100ps
module i2css_master (
    // resolved data line
    input  wire logic sda,
    // pulls, high drags the line low
    output logic      scl_pull,
    output logic      sda_pull
);
    // released lines, clock stands high between frames
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // start: data falls while clock high
    task automatic start();
        sda_pull = 1'b1;
        #16 scl_pull = 1'b1;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        #16 sda_pull = 1'b1;
        #16 scl_pull = 1'b0;
        #16 sda_pull = 1'b0;
        #16;
    endtask
    // one bit of 64 ns, slower than twelve block clocks
    task automatic bit_io(input logic b, output logic r);
        #16 sda_pull = !b;
        #16 scl_pull = 1'b0;
        #16 r = sda;
        #16 scl_pull = 1'b1;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ak, a);
    endtask
endmodule

// ### dv/testbench.sv
// testbench: self-checking bench of the i2c slave status block
// assumes i2css_top, the bus master model and the port checker
`timescale 1ns/100ps
module testbench;
    logic        clock, sys_rst, reg_wr, reg_rd, bus_free_req, rd_d, a;
    logic [15:0] reg_addr, reg_wdata, seed, tx_byte;
    logic [15:0] exp_q[$], msk_q[$];
    logic [7:0]  q;
    wire  [15:0] reg_rdata;
    wire         scl, sda, oe, dout, irq_bus_status, irq_receive, irq_transmit, m_scl, m_sda;
    int          n_mismatch = 0, checked = 0, n_rx = 0, n_tx = 0, cycles = 0;
    // open-drain lines with pull-ups
    assign scl = !m_scl;
    assign sda = !(m_sda || (oe && !dout));
    i2css_top i_i2css_top (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bus_clock_line_in(scl), .bus_data_line_in(sda), .bus_data_line_out(dout),
        .bus_data_line_oe(oe), .bus_free_req, .irq_bus_status, .irq_receive, .irq_transmit);
    i2css_master i_i2css_master (.sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = !clock;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            $display("FAIL %s expected %h seen %h", what, e, s);
            n_mismatch++;
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [15:0] ad, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // gap first lets line events pass the synchronisers; #1 lets edge updates land
    task automatic rd(input logic [15:0] ad, input logic [15:0] e, input logic [15:0] m);
        repeat (4) @(posedge clock);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
    endtask
    // watcher: read answers, request pulses and the hang limit
    always @(posedge clock) begin
        rd_d <= reg_rd;
        n_rx <= n_rx + int'(irq_receive);
        n_tx <= n_tx + int'(irq_transmit);
        cycles <= cycles + 1;
        if (rd_d && exp_q.size() > 0)
            chk("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        sys_rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bus_free_req = 1'b0;
        seed = 16'h87d9;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'hffff);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0000, 16'hffff);
        rd(i2css_pkg::OFS_IRQ_ENABLE, 16'h0000, 16'hffff);
        rd(16'h4366, 16'h0000, 16'hffff);
        wr(i2css_pkg::OFS_IRQ_ENABLE, 16'hffff);
        rd(i2css_pkg::OFS_IRQ_ENABLE, 16'h0007, 16'hffff);
        $display("test registers done");
        // master write of one random byte to own address
        wr(i2css_pkg::OFS_CONTROL, 16'h002a);
        seed = lfsr(seed);
        i_i2css_master.start();
        i_i2css_master.xfer(8'h54, 1'b1, q, a);
        chk("address ack", 16'h0000, {15'h0000, a});
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0006, 16'h001f);
        i_i2css_master.xfer(seed[7:0], 1'b1, q, a);
        chk("data ack", 16'h0000, {15'h0000, a});
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0016, 16'h001f);
        rd(i2css_pkg::OFS_RECEIVE, {8'h00, seed[7:0]}, 16'hffff);
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'h0010);
        chk("receive irq count", 16'h0001, 16'(n_rx));
        i_i2css_master.stop();
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'h0006);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0081, 16'hffff);
        chk("bus irq", 16'h0001, {15'h0000, irq_bus_status});
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h0000);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0081, 16'hffff);
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h003f);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0000, 16'hffff);
        chk("bus irq", 16'h0000, {15'h0000, irq_bus_status});
        $display("test master write done");
        // master read: first byte acked, second byte top bit forced low and refused
        seed = lfsr(seed);
        tx_byte = {8'h00, seed[7:0] | 8'h80};
        wr(i2css_pkg::OFS_TRANSMIT, tx_byte);
        i_i2css_master.start();
        i_i2css_master.xfer(8'h55, 1'b1, q, a);
        chk("address ack", 16'h0000, {15'h0000, a});
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0007, 16'h0007);
        chk("transmit irq count", 16'h0001, 16'(n_tx));
        i_i2css_master.xfer(8'hff, 1'b0, q, a);
        chk("read byte", tx_byte, {8'h00, q});
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0008, 16'h0008);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0000, 16'h000a);
        i_i2css_master.xfer(8'h7f, 1'b1, q, a);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h008a, 16'h008a);
        i_i2css_master.stop();
        wr(i2css_pkg::OFS_TRANSMIT, tx_byte);
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'h0008);
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h003f);
        $display("test master read done");
        // asynchronous detection answers nak and does not select
        wr(i2css_pkg::OFS_CONTROL, 16'h012a);
        i_i2css_master.start();
        i_i2css_master.xfer(8'h54, 1'b1, q, a);
        chk("async nak", 16'h0001, {15'h0000, a});
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0084, 16'h00bf);
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'h0002);
        i_i2css_master.stop();
        // foreign address acked by another slave: no mismatch in async mode
        i_i2css_master.start();
        i_i2css_master.xfer(8'h56, 1'b0, q, a);
        i_i2css_master.stop();
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0084, 16'h00bf);
        wr(i2css_pkg::OFS_CONTROL, 16'h002a);
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h003f);
        // same outside async mode: mismatch raised while not selected
        i_i2css_master.start();
        i_i2css_master.xfer(8'h56, 1'b0, q, a);
        i_i2css_master.stop();
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0088, 16'h00bf);
        rd(i2css_pkg::OFS_ACCESS_STATUS, 16'h0000, 16'h0002);
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h003f);
        $display("test async detect done");
        // bus free request, then the bus request masked off
        @(posedge clock);
        bus_free_req <= 1'b1;
        @(posedge clock);
        bus_free_req <= 1'b0;
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0090, 16'hffff);
        chk("bus irq", 16'h0001, {15'h0000, irq_bus_status});
        wr(i2css_pkg::OFS_IRQ_ENABLE, 16'h0000);
        rd(i2css_pkg::OFS_IRQ_ENABLE, 16'h0000, 16'hffff);
        chk("bus irq", 16'h0000, {15'h0000, irq_bus_status});
        wr(i2css_pkg::OFS_BUS_STATUS, 16'h003f);
        rd(i2css_pkg::OFS_BUS_STATUS, 16'h0000, 16'hffff);
        $display("test bus free done");
        end_sim();
    end
endmodule
bind i2css_top i2css_props i_i2css_props (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bus_clock_line_in, .bus_data_line_in, .bus_data_line_out,
    .bus_data_line_oe, .bus_free_req, .irq_bus_status, .irq_receive, .irq_transmit);
